/* File: cif_defines.svh */
// Constants for the counter input front end.
`ifndef CIF_DEFINES_SVH
`define CIF_DEFINES_SVH
`define CIF_CLK_KHZ 50000
`define CIF_DLY_005_US 50
`define CIF_DLY_010_US 100
`define CIF_DLY_040_US 400
`define CIF_DLY_160_US 1600
`define CIF_DLY_320_US 3200
`define CIF_DLY_1280_US 12800
`define CIF_DLY_2000_US 20000
`define CIF_US_CYC(us) (((us) * 50000 + 999) / 1000)
`define CIF_CNT_W 20
`define CIF_SEL_NONE 3'h0
`define CIF_SEL_DEFAULT 3'h5
`define CIF_ADDR_FILT 12'h000
`define CIF_ADDR_MODE 12'h004
`define CIF_ADDR_AUX 12'h008
`define CIF_ADDR_STAT 12'h00c
`define CIF_ADDR_GPI 12'h010
`define CIF_ADDR_POS 12'h014
`define CIF_ADDR_CLR 12'h018
`define CIF_NUM_IN 8
`define CIF_IN_A 0
`define CIF_IN_B 1
`define CIF_IN_N 2
`define CIF_IN_AUX0 3
`define CIF_IN_AUX1 4
`endif

/* File: cif_pkg.sv */
// Types shared by the counter input front end.
package cif_pkg;
  typedef enum logic [2:0] {
    CIF_QUAD_N = 3'h0,
    CIF_QUAD = 3'h1,
    CIF_PULSE = 3'h2,
    CIF_PULSE_DIR = 3'h3,
    CIF_UPDOWN = 3'h4
  } cif_mode_type;
  typedef enum logic [1:0] {
    CIF_AUX_PLAIN = 2'h0,
    CIF_AUX_GATE = 2'h1,
    CIF_AUX_SYNC = 2'h2,
    CIF_AUX_CAPTURE = 2'h3
  } cif_aux_type;
  typedef struct packed {
    logic countUp;
    logic countDown;
    logic zeroMark;
    logic gate;
    logic sync;
    logic capture;
  } cif_event_type;
endpackage

/* File: cif_filter.sv */
// One debounce filter channel with selectable delay.
`timescale 1ns/100ps
`default_nettype none
`include "cif_defines.svh"
module cif_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic [2:0] delaySel,
  // Data
  input wire logic rawIn,
  output logic filtOut
);
  import cif_pkg::*;
  logic [`CIF_CNT_W-1:0] cnt_reg;
  logic filt_reg;
  logic [`CIF_CNT_W-1:0] limit;
  logic differ;
  function automatic logic [`CIF_CNT_W-1:0] cycles(input logic [2:0] sel);
    case (sel)
      3'h1: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_005_US));
      3'h2: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_010_US));
      3'h3: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_040_US));
      3'h4: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_160_US));
      3'h5: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_320_US));
      3'h6: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_1280_US));
      3'h7: cycles = `CIF_CNT_W'(`CIF_US_CYC(`CIF_DLY_2000_US));
      default: cycles = '0;
    endcase
  endfunction
  assign limit = cycles(delaySel);
  assign differ = rawIn != filt_reg;
  assign filtOut = filt_reg;
  // The new level must hold for the whole delay; any bounce restarts the count.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      filt_reg <= 1'b0;
    end else if (!differ) begin
      cnt_reg <= '0;
    end else if (delaySel == `CIF_SEL_NONE || cnt_reg + 1'b1 >= limit) begin
      cnt_reg <= '0;
      filt_reg <= rawIn;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  chk_filter_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(filt_reg) && delaySel != `CIF_SEL_NONE |-> $past(differ)) else $error("filter changed early");
endmodule // cif_filter
`default_nettype wire

/* File: cif_frontend.sv */
// Counter input front end: filters, encoder decode, aux routing, APB registers.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "cif_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Delay filter selects none through 20 ms.
// - Reset or unset filter gives 3.2 ms. Here only reset loads 3.2 ms; a select of 0 gives no filter.
// - Quadrature A/B plus zero mark N.
// - Quadrature A/B, zero mark ignored.
// - Count pulses on A, B ignored.
// - Pulses on A, direction from B.
// - A counts up, B counts down.
// - Two aux inputs: gate, sync or capture.
// - Unassigned aux input state reported to software.
// - Unused inputs readable as general inputs.
module cif_frontend (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Raw digital inputs
  input wire logic [`CIF_NUM_IN-1:0] rawIn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded events to the counter core
  output cif_pkg::cif_event_type evt
);
  import cif_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0] filtSel_reg;
  logic [2:0] mode_reg;
  logic [1:0] aux0Fn_reg;
  logic [1:0] aux1Fn_reg;
  logic [31:0] pos_reg;
  logic [31:0] capt_reg;
  logic [`CIF_NUM_IN-1:0] prev_reg;
  cif_event_type evt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [`CIF_NUM_IN-1:0] filt;
  logic [2:0] useSel;
  ////////////////////////////////////////////////////////////////////////////////
  // Setting 0 in the select field already means no filter, so reset loads 3.2 ms.
  assign useSel = filtSel_reg;
  genvar gi;
  generate
    for (gi = 0; gi < `CIF_NUM_IN; gi++) begin : gFilt
      cif_filter uFilt (
        .sys_clk(sys_clk),
        .rst(rst),
        .delaySel(useSel),
        .rawIn(rawIn[gi]),
        .filtOut(filt[gi])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////////
  wire a = filt[`CIF_IN_A];
  wire b = filt[`CIF_IN_B];
  wire n = filt[`CIF_IN_N];
  wire pa = prev_reg[`CIF_IN_A];
  wire pb = prev_reg[`CIF_IN_B];
  wire pn = prev_reg[`CIF_IN_N];
  wire aRise = a & ~pa;
  wire bRise = b & ~pb;
  wire aEdge = a ^ pa;
  wire bEdge = b ^ pb;
  // Quadrature: A leading B by 90 degrees counts up; one step per edge.
  wire quadUp = (aEdge & (a ^ b)) | (bEdge & ~(a ^ b));
  wire quadDn = (aEdge & ~(a ^ b)) | (bEdge & (a ^ b));
  wire quadOk = ~(aEdge & bEdge);
  wire isQuad = mode_reg == CIF_QUAD_N || mode_reg == CIF_QUAD;
  wire upNext = isQuad ? quadUp & quadOk :
    (mode_reg == CIF_PULSE) ? aRise :
    (mode_reg == CIF_PULSE_DIR) ? aRise & ~b :
    (mode_reg == CIF_UPDOWN) ? aRise & ~bRise : 1'b0;
  wire dnNext = isQuad ? quadDn & quadOk :
    (mode_reg == CIF_PULSE_DIR) ? aRise & b :
    (mode_reg == CIF_UPDOWN) ? bRise & ~aRise : 1'b0;
  wire zeroNext = (mode_reg == CIF_QUAD_N) & n & ~pn;
  wire x0 = filt[`CIF_IN_AUX0];
  wire x1 = filt[`CIF_IN_AUX1];
  wire x0Rise = x0 & ~prev_reg[`CIF_IN_AUX0];
  wire x1Rise = x1 & ~prev_reg[`CIF_IN_AUX1];
  // A gate with no aux input assigned is held open.
  wire gateNext = ~((aux0Fn_reg == CIF_AUX_GATE) & ~x0) & ~((aux1Fn_reg == CIF_AUX_GATE) & ~x1);
  wire syncNext = ((aux0Fn_reg == CIF_AUX_SYNC) & x0Rise) | ((aux1Fn_reg == CIF_AUX_SYNC) & x1Rise);
  wire captNext = ((aux0Fn_reg == CIF_AUX_CAPTURE) & x0Rise) | ((aux1Fn_reg == CIF_AUX_CAPTURE) & x1Rise);
  wire posStep = gateNext & (upNext | dnNext);
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs not serving the chosen encoder type or an aux function read as plain inputs.
  wire [`CIF_NUM_IN-1:0] usedMask = {{(`CIF_NUM_IN-5){1'b0}},
    aux1Fn_reg != CIF_AUX_PLAIN, aux0Fn_reg != CIF_AUX_PLAIN,
    mode_reg == CIF_QUAD_N,
    mode_reg != CIF_PULSE, 1'b1};
  wire [31:0] gpiWord = 32'(filt & ~usedMask);
  wire [31:0] statWord = {26'h0, x1, x0, n, b, a, gateNext};
  wire setup = psel & ~penable;
  wire wrTake = psel & penable & pwrite & pready_reg;
  wire addrOk = paddr == `CIF_ADDR_FILT || paddr == `CIF_ADDR_MODE || paddr == `CIF_ADDR_AUX ||
    paddr == `CIF_ADDR_STAT || paddr == `CIF_ADDR_GPI || paddr == `CIF_ADDR_POS || paddr == `CIF_ADDR_CLR;
  wire modeOk = pwdata[2:0] <= 3'(CIF_UPDOWN);
  wire [31:0] rdNext = (paddr == `CIF_ADDR_FILT) ? {29'h0, filtSel_reg} :
    (paddr == `CIF_ADDR_MODE) ? {29'h0, mode_reg} :
    (paddr == `CIF_ADDR_AUX) ? {28'h0, aux1Fn_reg, aux0Fn_reg} :
    (paddr == `CIF_ADDR_STAT) ? statWord :
    (paddr == `CIF_ADDR_GPI) ? gpiWord :
    (paddr == `CIF_ADDR_POS) ? pos_reg :
    (paddr == `CIF_ADDR_CLR) ? capt_reg : 32'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // APB answers one cycle after setup; pready pulses for one access cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~addrOk;
      prdata_reg <= (setup & ~pwrite) ? rdNext : 32'h0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filtSel_reg <= `CIF_SEL_DEFAULT;
      mode_reg <= 3'(CIF_QUAD_N);
      aux0Fn_reg <= CIF_AUX_PLAIN;
      aux1Fn_reg <= CIF_AUX_PLAIN;
    end else if (wrTake) begin
      if (paddr == `CIF_ADDR_FILT) filtSel_reg <= pwdata[2:0];
      if (paddr == `CIF_ADDR_MODE && modeOk) mode_reg <= pwdata[2:0];
      if (paddr == `CIF_ADDR_AUX) begin
        aux0Fn_reg <= pwdata[1:0];
        aux1Fn_reg <= pwdata[3:2];
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_reg <= '0;
      evt_reg <= '0;
      pos_reg <= 32'h0;
      capt_reg <= 32'h0;
    end else begin
      prev_reg <= filt;
      evt_reg <= '{countUp: upNext & gateNext, countDown: dnNext & gateNext, zeroMark: zeroNext,
        gate: gateNext, sync: syncNext, capture: captNext};
      if (syncNext) pos_reg <= 32'h0;
      else if (posStep) pos_reg <= upNext ? pos_reg + 32'h1 : pos_reg - 32'h1;
      if (captNext) capt_reg <= pos_reg;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign evt = evt_reg;
  ////////////////////////////////////////////////////////////////////////////////
  chk_reset_delay: assert property (@(posedge sys_clk) rst |=> filtSel_reg == `CIF_SEL_DEFAULT)
    else $error("default delay not set");
  chk_quad_nozero: assert property (@(posedge sys_clk) disable iff (rst)
    mode_reg == CIF_QUAD |-> ##1 !evt.zeroMark) else $error("zero mark in mode without N");
  chk_zero_mark: assert property (@(posedge sys_clk) disable iff (rst)
    mode_reg == CIF_QUAD_N && n && !pn |=> evt.zeroMark) else $error("zero mark lost");
  chk_pulse_up: assert property (@(posedge sys_clk) disable iff (rst)
    mode_reg == CIF_PULSE && aRise && gateNext |=> evt.countUp && !evt.countDown) else $error("pulse miss");
  chk_dir_level: assert property (@(posedge sys_clk) disable iff (rst)
    mode_reg == CIF_PULSE_DIR && aRise && b && gateNext |=> evt.countDown) else $error("dir wrong");
  chk_updown_b: assert property (@(posedge sys_clk) disable iff (rst)
    mode_reg == CIF_UPDOWN && bRise && !aRise && gateNext |=> evt.countDown) else $error("down miss");
  chk_gate_closed: assert property (@(posedge sys_clk) disable iff (rst)
    aux0Fn_reg == CIF_AUX_GATE && !x0 |=> !evt.gate && !evt.countUp) else $error("gate ignored");
  chk_apb_answer: assert property (@(posedge sys_clk) disable iff (rst)
    setup |=> pready ##1 !pready) else $error("apb answer late");
  chk_gpi_free: assert property (@(posedge sys_clk) disable iff (rst)
    aux0Fn_reg == CIF_AUX_PLAIN |-> gpiWord[`CIF_IN_AUX0] == x0) else $error("gpi masked");
  cov_quad_up: cover property (@(posedge sys_clk) disable iff (rst) isQuad && evt.countUp);
  cov_capture: cover property (@(posedge sys_clk) disable iff (rst) evt.capture);
  cov_sync: cover property (@(posedge sys_clk) disable iff (rst) evt.sync);
endmodule // cif_frontend
`default_nettype wire

/* File: cif_encoder_model.sv */
// Behavioural encoder that drives the A, B, N and auxiliary input lines.
`timescale 1ns/100ps
`default_nettype none
`include "cif_defines.svh"
module cif_encoder_model (
  // Clock
  input wire logic sys_clk,
  // Sensor lines
  output logic [`CIF_NUM_IN-1:0] sensorOut
);
  int holdCyc = 6;
  initial sensorOut = '0;
  // Push-pull drive, so a line never floats between levels.
  task automatic setLine(input int idx, input logic lvl);
    @(posedge sys_clk);
    sensorOut[idx] <= lvl;
    repeat (holdCyc) @(posedge sys_clk);
  endtask
  task automatic pulse(input int idx);
    setLine(idx, 1'b1);
    setLine(idx, 1'b0);
  endtask
  // One forward cycle: A leads B by a quarter period.
  task automatic quadCycle();
    setLine(`CIF_IN_A, 1'b1);
    setLine(`CIF_IN_B, 1'b1);
    setLine(`CIF_IN_A, 1'b0);
    setLine(`CIF_IN_B, 1'b0);
  endtask
endmodule // cif_encoder_model
`default_nettype wire

/* File: test_cif_frontend.sv */
// Self-checking testbench for the counter input front end.
`timescale 1ns/100ps
`default_nettype none
`include "cif_defines.svh"
module test_cif_frontend;
  import cif_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdVal;
  logic pready;
  logic pslverr;
  logic errVal;
  logic [`CIF_NUM_IN-1:0] rawIn;
  cif_event_type evt;
  int err_total = 0;
  int samples_checked = 0;
  int upCnt = 0;
  int dnCnt = 0;
  int zCnt = 0;
  int capCnt = 0;
  int syncCnt = 0;
  int expUp[5] = '{4, 4, 2, 0, 1};
  int expDn[5] = '{0, 0, 0, 2, 2};
  int expZ[5] = '{1, 0, 0, 0, 0};
  cif_frontend DUT (.sys_clk(sys_clk), .rst(rst), .rawIn(rawIn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt));
  cif_encoder_model enc (.sys_clk(sys_clk), .sensorOut(rawIn));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    upCnt <= upCnt + int'(evt.countUp === 1'b1);
    dnCnt <= dnCnt + int'(evt.countDown === 1'b1);
    zCnt <= zCnt + int'(evt.zeroMark === 1'b1);
    capCnt <= capCnt + int'(evt.capture === 1'b1);
    syncCnt <= syncCnt + int'(evt.sync === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("mismatches=%0d checks=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The wait has no bound of its own; only the watchdog ends a silent slave.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tReset();
    apb(1'b0, `CIF_ADDR_FILT, 32'h0);
    chk(rdVal, 32'h5);
    apb(1'b0, `CIF_ADDR_AUX, 32'h0);
    chk(rdVal, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk({rdVal[30:0], errVal}, 32'h1);
  endtask
  // Timing is shown on the 0.05 ms step; steps of 0.4 ms and longer would exceed the run budget.
  task automatic tFilter();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `CIF_ADDR_FILT, 32'(i));
      apb(1'b0, `CIF_ADDR_FILT, 32'h0);
      chk(rdVal, 32'(i));
    end
    apb(1'b1, `CIF_ADDR_FILT, 32'h1);
    enc.holdCyc = 2400;
    enc.setLine(`CIF_IN_A, 1'b1);
    apb(1'b0, `CIF_ADDR_STAT, 32'h0);
    chk(rdVal[1], 1'b0);
    repeat (200) @(posedge sys_clk);
    apb(1'b0, `CIF_ADDR_STAT, 32'h0);
    chk(rdVal[1], 1'b1);
    enc.holdCyc = 2600;
    enc.setLine(`CIF_IN_A, 1'b0);
    enc.holdCyc = 6;
    apb(1'b1, `CIF_ADDR_FILT, 32'h0);
  endtask
  task automatic tModes();
    int u;
    int dd;
    int z;
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, `CIF_ADDR_MODE, 32'(m));
      u = upCnt;
      dd = dnCnt;
      z = zCnt;
      case (m)
        0, 1: begin
          enc.quadCycle();
          enc.pulse(`CIF_IN_N);
        end
        4: begin
          enc.pulse(`CIF_IN_A);
          enc.pulse(`CIF_IN_B);
          enc.pulse(`CIF_IN_B);
        end
        default: begin
          enc.setLine(`CIF_IN_B, 1'b1);
          enc.pulse(`CIF_IN_A);
          enc.pulse(`CIF_IN_A);
          enc.setLine(`CIF_IN_B, 1'b0);
        end
      endcase
      repeat (8) @(posedge sys_clk);
      chk(32'(upCnt - u), 32'(expUp[m]));
      chk(32'(dnCnt - dd), 32'(expDn[m]));
      chk(32'(zCnt - z), 32'(expZ[m]));
    end
    apb(1'b1, `CIF_ADDR_MODE, 32'h5);
    apb(1'b0, `CIF_ADDR_MODE, 32'h0);
    chk(rdVal, 32'h4);
  endtask
  task automatic tAux();
    int c;
    int s;
    c = capCnt;
    s = syncCnt;
    apb(1'b1, `CIF_ADDR_AUX, 32'hb);
    enc.pulse(`CIF_IN_AUX0);
    enc.pulse(`CIF_IN_AUX1);
    chk(32'(capCnt - c), 32'h1);
    chk(32'(syncCnt - s), 32'h1);
    apb(1'b0, `CIF_ADDR_CLR, 32'h0);
    chk(rdVal, 32'h7);
    apb(1'b0, `CIF_ADDR_POS, 32'h0);
    chk(rdVal, 32'h0);
    apb(1'b1, `CIF_ADDR_AUX, 32'h1);
    enc.setLine(`CIF_IN_AUX0, 1'b1);
    chk(evt.gate, 1'b1);
    enc.setLine(`CIF_IN_AUX0, 1'b0);
    chk(evt.gate, 1'b0);
    apb(1'b1, `CIF_ADDR_AUX, 32'h0);
    enc.setLine(`CIF_IN_AUX1, 1'b1);
    enc.setLine(5, 1'b1);
    apb(1'b0, `CIF_ADDR_STAT, 32'h0);
    chk(rdVal[5], 1'b1);
    apb(1'b0, `CIF_ADDR_GPI, 32'h0);
    chk(rdVal[5], 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tReset();
    tFilter();
    tModes();
    tAux();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
endmodule // test_cif_frontend
`default_nettype wire
